/* File: src/pcg_pkg.sv */
// Shared constants, register map and carrier types of the PWM and capture timer group
package pcg_pkg;

    // Channel organisation
    localparam int NUM_CH   = 8;
    localparam int NUM_PAIR = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_PRESCALE = 8'h00;
    localparam logic [7:0] OFS_CLKDIV   = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_DEADTIME = 8'h0C;
    localparam logic [7:0] OFS_PERIOD   = 8'h10;
    localparam logic [7:0] OFS_COMPARE  = 8'h30;
    localparam logic [7:0] OFS_COUNT    = 8'h50;
    localparam logic [7:0] OFS_PWM_IE   = 8'h70;
    localparam logic [7:0] OFS_PWM_ST   = 8'h74;
    localparam logic [7:0] OFS_CAPCTL   = 8'h78;
    localparam logic [7:0] OFS_CAP_ST   = 8'h88;
    localparam logic [7:0] OFS_RISE     = 8'h90;
    localparam logic [7:0] OFS_FALL     = 8'hB0;

    // Field positions
    localparam int CTRL_EN_LSB  = 0;
    localparam int CTRL_AR_LSB  = 8;
    localparam int CTRL_DZ_LSB  = 16;
    localparam int CLKDIV_W     = 4;
    localparam int CAP_EN_BIT   = 0;
    localparam int CAP_RIE_BIT  = 1;
    localparam int CAP_FIE_BIT  = 2;
    localparam int CAP_HALF_LSB = 16;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcg_bus_req_t;

    // Configuration handed to one channel timer
    typedef struct packed {
        logic        enable;
        logic        auto_reload;
        logic [2:0]  div_sel;
        logic [15:0] period;
        logic [15:0] compare;
    } pcg_tmr_cfg_t;

    // Status returned by one channel timer
    typedef struct packed {
        logic [15:0] count;
        logic        zero;
        logic        level;
    } pcg_tmr_stat_t;

    // Divider mask: 0..4 select 1, 1/2, 1/4, 1/8, 1/16
    function automatic logic [3:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    div_mask = 4'h0;
            3'h1:    div_mask = 4'h1;
            3'h2:    div_mask = 4'h3;
            3'h3:    div_mask = 4'h7;
            default: div_mask = 4'hF;
        endcase
    endfunction

    // Decode an address inside an eight-word array at base
    function automatic logic [3:0] arr_hit(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        arr_hit = {(addr >= base) && (rel < 8'h20) && (rel[1:0] == 2'h0), rel[4:2]};
    endfunction

endpackage

/* File: src/pcg_timer.sv */
// One channel timer: divider, double-buffered 16-bit down-counter and comparator
module pcg_timer (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    // Prescaled tick and configuration
    input  wire logic                   pre_tick,
    input  pcg_pkg::pcg_tmr_cfg_t       cfg,
    // Timer status
    output pcg_pkg::pcg_tmr_stat_t      stat
);

    typedef struct packed {
        logic [3:0]  div_cnt;
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic        run;
        logic        started;
        logic        level;
        logic        zero;
    } pcg_tmr_state_t;

    pcg_tmr_state_t s_q;
    pcg_tmr_state_t s_d;
    logic           tick;

    // Divided tick selected by the divider setting
    assign tick = pre_tick && ((s_q.div_cnt & pcg_pkg::div_mask(cfg.div_sel))
                               == pcg_pkg::div_mask(cfg.div_sel));

    // Next-state logic of the counter
    always_comb begin
        s_d      = s_q;
        s_d.zero = 1'b0;
        if (pre_tick) begin
            s_d.div_cnt = s_q.div_cnt + 4'h1;
        end
        if (!cfg.enable) begin
            s_d.run     = 1'b0;
            s_d.started = 1'b0;
            s_d.level   = 1'b0;
            s_d.div_cnt = 4'h0;
        end else if (!s_q.started) begin
            // First enable cycle loads both buffers
            s_d.started = 1'b1;
            s_d.run     = 1'b1;
            s_d.cnt     = cfg.period;
            s_d.cmp     = cfg.compare;
            s_d.level   = 1'b0;
        end else if (s_q.run && tick) begin
            if (s_q.cnt == 16'h0000) begin
                s_d.zero = 1'b1;
                if (cfg.auto_reload) begin
                    s_d.cnt   = cfg.period;
                    s_d.cmp   = cfg.compare;
                    s_d.level = 1'b0;
                end else begin
                    s_d.run = 1'b0;
                end
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
                if ((s_q.cnt - 16'h0001) == s_q.cmp) begin
                    s_d.level = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign stat.count = s_q.cnt;
    assign stat.zero  = s_q.zero;
    assign stat.level = s_q.level;

endmodule // pcg_timer

/* File: src/pcg_top.sv */
// Top of the PWM generator and capture timer group with its register port
//
// The implementer's own choices: the placing of the registers and the strobed register port.

module pcg_top #(
    parameter int PRE_W = 8
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    // Register port
    input  pcg_pkg::pcg_bus_req_t       bus_req,
    output logic [31:0]                 rdata,
    // Pins
    output logic [7:0]                  pwm_out,
    output logic [7:0]                  pwm_oe,
    input  wire logic [7:0]             cap_in,
    // Interrupt
    output logic                        irq
);

    typedef struct packed {
        logic [3:0][PRE_W-1:0] prescale;
        logic [3:0][PRE_W-1:0] pre_cnt;
        logic [31:0]           clkdiv;
        logic [31:0]           ctrl;
        logic [3:0][7:0]       deadtime;
        logic [7:0][15:0]      period;
        logic [7:0][15:0]      compare;
        logic [7:0]            pwm_ie;
        logic [7:0]            pwm_st;
        logic [3:0][31:0]      capctl;
        logic [15:0]           cap_st;
        logic [7:0][15:0]      rise;
        logic [7:0][15:0]      fall;
        logic [7:0]            cap_prev;
        logic [3:0]            dz_prev;
        logic [3:0][7:0]       dz_cnt;
        logic [7:0]            pin_out;
        logic [31:0]           rdata;
    } pcg_core_state_t;

    pcg_core_state_t                    s_q;
    pcg_core_state_t                    s_d;
    pcg_pkg::pcg_tmr_cfg_t [7:0]        tmr_cfg;
    pcg_pkg::pcg_tmr_stat_t [7:0]       tmr_stat;
    logic [3:0]                         pre_tick;
    logic [7:0]                         cap_en;

    // Reads one capture control bit of a channel
    function automatic logic cap_bit(input logic [3:0][31:0] ctl, input int ch,
                                     input int b);
        cap_bit = ctl[ch / 2][(ch % 2) * pcg_pkg::CAP_HALF_LSB + b];
    endfunction

    // Prescaler ticks, one per generator shared by both its channels
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            pre_tick[g] = (s_q.pre_cnt[g] == s_q.prescale[g]);
        end
    end

    // Capture enables and timer configuration
    always_comb begin
        for (int ch = 0; ch < 8; ch++) begin
            cap_en[ch]              = cap_bit(s_q.capctl, ch, pcg_pkg::CAP_EN_BIT);
            tmr_cfg[ch].enable      = s_q.ctrl[pcg_pkg::CTRL_EN_LSB + ch];
            tmr_cfg[ch].auto_reload = s_q.ctrl[pcg_pkg::CTRL_AR_LSB + ch];
            tmr_cfg[ch].div_sel     = s_q.clkdiv[ch * pcg_pkg::CLKDIV_W +: 3];
            tmr_cfg[ch].period      = s_q.period[ch];
            tmr_cfg[ch].compare     = s_q.compare[ch];
        end
    end

    // Eight channel timers, two per generator
    for (genvar ch = 0; ch < 8; ch++) begin : g_tmr
        pcg_timer u_tmr (
            .core_clk (core_clk),
            .nrst     (nrst),
            .pre_tick (pre_tick[ch / 2]),
            .cfg      (tmr_cfg[ch]),
            .stat     (tmr_stat[ch])
        );
    end

    // Next-state logic: registers, flags, capture, dead zone and read data
    always_comb begin
        logic [3:0] hit;
        logic       rd_pwm_st;
        logic       rd_cap_st;
        logic       base;
        logic       settled;
        logic       pair_en;
        hit       = 4'h0;
        rd_pwm_st = 1'b0;
        rd_cap_st = 1'b0;
        base      = 1'b0;
        settled   = 1'b0;
        pair_en   = 1'b0;
        s_d       = s_q;

        // Prescaler counters
        for (int g = 0; g < 4; g++) begin
            if (pre_tick[g]) begin
                s_d.pre_cnt[g] = '0;
            end else begin
                s_d.pre_cnt[g] = s_q.pre_cnt[g] + 1'b1;
            end
        end

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                pcg_pkg::OFS_PRESCALE: begin
                    for (int g = 0; g < 4; g++) begin
                        s_d.prescale[g] = bus_req.wdata[g * 8 +: PRE_W];
                    end
                end
                pcg_pkg::OFS_CLKDIV:   s_d.clkdiv = bus_req.wdata;
                pcg_pkg::OFS_CTRL:     s_d.ctrl = bus_req.wdata;
                pcg_pkg::OFS_DEADTIME: s_d.deadtime = bus_req.wdata;
                pcg_pkg::OFS_PWM_IE:   s_d.pwm_ie = bus_req.wdata[7:0];
                default: begin
                end
            endcase
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_PERIOD);
            if (hit[3]) begin
                s_d.period[hit[2:0]] = bus_req.wdata[15:0];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_COMPARE);
            if (hit[3]) begin
                s_d.compare[hit[2:0]] = bus_req.wdata[15:0];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_CAPCTL);
            if (hit[3] && (hit[2] == 1'b0)) begin
                s_d.capctl[hit[1:0]] = bus_req.wdata;
            end
        end

        // Reading a status register clears it; new events below win
        if (bus_req.rd && (bus_req.addr == pcg_pkg::OFS_PWM_ST)) begin
            rd_pwm_st = 1'b1;
            s_d.pwm_st = 8'h00;
        end
        if (bus_req.rd && (bus_req.addr == pcg_pkg::OFS_CAP_ST)) begin
            rd_cap_st = 1'b1;
            s_d.cap_st = 16'h0000;
        end

        // Period flags, one per channel
        for (int ch = 0; ch < 8; ch++) begin
            if (tmr_stat[ch].zero) begin
                s_d.pwm_st[ch] = 1'b1;
            end
        end

        // Capture edges latch the counter of the same-index timer
        for (int ch = 0; ch < 8; ch++) begin
            s_d.cap_prev[ch] = cap_in[ch];
            if (cap_en[ch] && cap_in[ch] && !s_q.cap_prev[ch]) begin
                s_d.rise[ch] = tmr_stat[ch].count;
                if (cap_bit(s_q.capctl, ch, pcg_pkg::CAP_RIE_BIT)) begin
                    s_d.cap_st[2 * ch] = 1'b1;
                end
            end
            if (cap_en[ch] && !cap_in[ch] && s_q.cap_prev[ch]) begin
                s_d.fall[ch] = tmr_stat[ch].count;
                if (cap_bit(s_q.capctl, ch, pcg_pkg::CAP_FIE_BIT)) begin
                    s_d.cap_st[2 * ch + 1] = 1'b1;
                end
            end
        end

        // Output levels with optional complementary pairing
        for (int p = 0; p < 4; p++) begin
            base           = tmr_stat[2 * p].level;
            pair_en        = s_q.ctrl[pcg_pkg::CTRL_EN_LSB + 2 * p];
            s_d.dz_prev[p] = base;
            if (base != s_q.dz_prev[p]) begin
                s_d.dz_cnt[p] = s_q.deadtime[p];
            end else if (s_q.dz_cnt[p] != 8'h00) begin
                s_d.dz_cnt[p] = s_q.dz_cnt[p] - 8'h01;
            end
            settled = (s_q.dz_cnt[p] == 8'h00) && (base == s_q.dz_prev[p]);
            if (s_q.ctrl[pcg_pkg::CTRL_DZ_LSB + p]) begin
                s_d.pin_out[2 * p]     = pair_en && base && settled;
                s_d.pin_out[2 * p + 1] = pair_en && !base && settled;
            end else begin
                s_d.pin_out[2 * p]     = tmr_stat[2 * p].level;
                s_d.pin_out[2 * p + 1] = tmr_stat[2 * p + 1].level;
            end
        end
        for (int ch = 0; ch < 8; ch++) begin
            if (cap_en[ch]) begin
                s_d.pin_out[ch] = 1'b0;
            end
        end

        // Read data, answered in the next cycle
        s_d.rdata = pcg_pkg::RST_WORD;
        if (bus_req.rd) begin
            case (bus_req.addr)
                pcg_pkg::OFS_PRESCALE: begin
                    for (int g = 0; g < 4; g++) begin
                        s_d.rdata[g * 8 +: PRE_W] = s_q.prescale[g];
                    end
                end
                pcg_pkg::OFS_CLKDIV:   s_d.rdata = s_q.clkdiv;
                pcg_pkg::OFS_CTRL:     s_d.rdata = s_q.ctrl;
                pcg_pkg::OFS_DEADTIME: s_d.rdata = s_q.deadtime;
                pcg_pkg::OFS_PWM_IE:   s_d.rdata[7:0] = s_q.pwm_ie;
                pcg_pkg::OFS_PWM_ST:   s_d.rdata[7:0] = s_q.pwm_st;
                pcg_pkg::OFS_CAP_ST:   s_d.rdata[15:0] = s_q.cap_st;
                default: begin
                end
            endcase
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_PERIOD);
            if (hit[3]) begin
                s_d.rdata[15:0] = s_q.period[hit[2:0]];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_COMPARE);
            if (hit[3]) begin
                s_d.rdata[15:0] = s_q.compare[hit[2:0]];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_COUNT);
            if (hit[3]) begin
                s_d.rdata[15:0] = tmr_stat[hit[2:0]].count;
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_CAPCTL);
            if (hit[3] && (hit[2] == 1'b0)) begin
                s_d.rdata = s_q.capctl[hit[1:0]];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_RISE);
            if (hit[3]) begin
                s_d.rdata[15:0] = s_q.rise[hit[2:0]];
            end
            hit = pcg_pkg::arr_hit(bus_req.addr, pcg_pkg::OFS_FALL);
            if (hit[3]) begin
                s_d.rdata[15:0] = s_q.fall[hit[2:0]];
            end
        end
        if (rd_pwm_st || rd_cap_st) begin
            s_d.rdata = s_d.rdata; // Status value captured before the clear
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rdata   = s_q.rdata;
    assign pwm_out = s_q.pin_out;
    assign pwm_oe  = ~cap_en;
    assign irq     = (|(s_q.pwm_st & s_q.pwm_ie)) || (|s_q.cap_st);

endmodule // pcg_top

/* File: sim/pcg_pin_model.sv */
// Outside world at the pins: driven pins loop back, others carry the source level
module pcg_pin_model (
    // Device side of the pins
    input  wire logic [7:0] pwm_out,
    input  wire logic [7:0] pwm_oe,
    // Level the outside source puts on pins the device has released
    input  wire logic [7:0] src_lvl,
    // Pin levels seen by the capture inputs
    output logic      [7:0] cap_in
);
    // A pin in capture mode shows only the source, never a stale device level
    assign cap_in = (pwm_oe & pwm_out) | (~pwm_oe & src_lvl);
endmodule // pcg_pin_model

/* File: sim/pcg_top_asserts.sv */
// Concurrent checks on the ports of the PWM and capture timer group
module pcg_top_asserts #(
    parameter int PRE_W = 8
) (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  nrst,
    // Register port
    input wire pcg_pkg::pcg_bus_req_t bus_req,
    input wire logic [31:0]           rdata,
    // Pins and interrupt
    input wire logic [7:0]            pwm_out,
    input wire logic [7:0]            pwm_oe,
    input wire logic [7:0]            cap_in,
    input wire logic                  irq
);
    logic [7:0]  ie_q;
    logic [3:0]  dz_q;
    logic [3:0]  dzp_q;
    logic [31:0] capw_q [4];
    logic [7:0]  cprev_q;
    logic        seen_q;
    logic [7:0]  cen;
    logic [7:0]  rie;
    logic [7:0]  fie;
    logic [3:0]  both;
    logic        wcap;

    // Capture control words sit between the control base and the status word
    assign wcap = bus_req.wr && bus_req.addr >= pcg_pkg::OFS_CAPCTL
                  && bus_req.addr < pcg_pkg::OFS_CAP_ST;

    // Shadow of the registers the checks depend on
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ie_q    <= 8'h00;
            dz_q    <= 4'h0;
            dzp_q   <= 4'h0;
            capw_q  <= '{default: 32'h0};
            cprev_q <= 8'h00;
            seen_q  <= 1'b0;
        end else begin
            dzp_q   <= dz_q;
            cprev_q <= cap_in;
            if (bus_req.wr && bus_req.addr == pcg_pkg::OFS_PWM_IE) begin
                ie_q <= bus_req.wdata[7:0];
            end
            if (bus_req.wr && bus_req.addr == pcg_pkg::OFS_CTRL) begin
                dz_q <= bus_req.wdata[19:16];
            end
            if (wcap) begin
                capw_q[bus_req.addr[3:2] + 2'h2] <= bus_req.wdata;
                seen_q <= seen_q | (|(bus_req.wdata & 32'h0006_0006));
            end
        end
    end

    // Per-channel capture enables and pair overlap
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            cen[n] = capw_q[n / 2][16 * (n % 2)];
            rie[n] = capw_q[n / 2][16 * (n % 2) + 1];
            fie[n] = capw_q[n / 2][16 * (n % 2) + 2];
        end
        for (int p = 0; p < 4; p++) begin
            both[p] = pwm_out[2 * p] & pwm_out[2 * p + 1];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_out_reset: assert property ($rose(nrst) |-> pwm_out == 8'h00 && !irq)
        else $error("outputs not quiet after reset");
    a_oe_follow: assert property (pwm_oe == ~cen)
        else $error("pin enable does not follow capture enable");
    a_cap_pin_low: assert property ((pwm_out & ~pwm_oe & ~$past(pwm_oe)) == 8'h00)
        else $error("output driven on a capture pin");
    a_irq_masked: assert property (ie_q == 8'h00 && !seen_q |-> !irq)
        else $error("interrupt without any enable");
    a_rise_irq: assert property (|(cap_in & ~cprev_q & cen & rie) |=> irq)
        else $error("rising capture gave no interrupt");
    a_fall_irq: assert property (|(~cap_in & cprev_q & cen & fie) |=> irq)
        else $error("falling capture gave no interrupt");
    a_dz_apart: assert property ((both & dz_q & dzp_q) == 4'h0)
        else $error("both outputs of a pair high");

    c_rise_seen: cover property (|(cap_in & ~cprev_q & cen & rie));
    c_dz_run: cover property (dz_q[0] && $rose(pwm_out[1]));
    c_irq_up: cover property ($rose(irq));
endmodule // pcg_top_asserts

bind pcg_top pcg_top_asserts #(.PRE_W(PRE_W)) i_pcg_top_asserts (
    .core_clk(core_clk),
    .nrst    (nrst),
    .bus_req (bus_req),
    .rdata   (rdata),
    .pwm_out (pwm_out),
    .pwm_oe  (pwm_oe),
    .cap_in  (cap_in),
    .irq     (irq)
);

/* File: sim/testbench.sv */
// Self-checking bench of the PWM and capture timer group
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  core_clk = 1'b0;
    logic                  nrst;
    pcg_pkg::pcg_bus_req_t bus_req;
    logic [31:0]           rdata;
    logic [7:0]            pwm_out;
    logic [7:0]            pwm_oe;
    logic [7:0]            cap_in;
    logic                  irq;
    logic [7:0]            src_lvl;
    int                    fails = 0;
    int                    num_checks = 0;

    pcg_top i_pcg_top (
        .core_clk(core_clk),
        .nrst    (nrst),
        .bus_req (bus_req),
        .rdata   (rdata),
        .pwm_out (pwm_out),
        .pwm_oe  (pwm_oe),
        .cap_in  (cap_in),
        .irq     (irq)
    );

    pcg_pin_model i_pcg_pin_model (
        .pwm_out(pwm_out),
        .pwm_oe (pwm_oe),
        .src_lvl(src_lvl),
        .cap_in (cap_in)
    );

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write takes one edge; the strobe drops for one cycle before the next access
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read and compare the answer in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        chk($sformatf("reg %h", a), e, rdata);
        @(posedge core_clk);
    endtask

    task automatic irqc(input logic e);
        @(negedge core_clk);
        chk("irq", 32'(e), 32'(irq));
        @(posedge core_clk);
    endtask

    // Count cycles until an output reaches a level
    task automatic wt(input int ch, input logic v, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (pwm_out[ch] !== v && n < 300);
    endtask

    task automatic meas(input int ch, output int hi, output int per);
        int lo;
        wt(ch, 1'b0, lo);
        wt(ch, 1'b1, lo);
        wt(ch, 1'b0, hi);
        wt(ch, 1'b1, lo);
        per = hi + lo;
        @(posedge core_clk);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog against a hung wait
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        give_verdict();
    end

    // Test sequence
    initial begin
        int h;
        int p;
        int sel;
        int pv;
        logic [7:0] offs [6];
        offs = '{pcg_pkg::OFS_CTRL, pcg_pkg::OFS_PWM_ST, pcg_pkg::OFS_CAPCTL,
                 pcg_pkg::OFS_CAP_ST, pcg_pkg::OFS_COUNT, 8'hF0};
        nrst    <= 1'b0;
        bus_req <= '0;
        src_lvl <= 8'h00;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        // Reset values, read-only counter, unmapped place
        wr(pcg_pkg::OFS_COUNT, 32'h0000_FFFF);
        wr(8'hF0, 32'hFFFF_FFFF);
        foreach (offs[i]) rc(offs[i], pcg_pkg::RST_WORD);
        $display("reset test done");
        // One-shot run on channel 0, flag masked then unmasked
        wr(pcg_pkg::OFS_PERIOD, 32'h4);
        wr(pcg_pkg::OFS_COMPARE, 32'h2);
        wr(pcg_pkg::OFS_CTRL, 32'h1);
        wt(0, 1'b1, h);
        chk("one shot pulse", 32'h1, 32'(h < 300));
        repeat (20) @(posedge core_clk);
        irqc(1'b0);
        wr(pcg_pkg::OFS_PWM_IE, 32'h1);
        irqc(1'b1);
        rc(pcg_pkg::OFS_PWM_ST, 32'h1);
        repeat (20) @(posedge core_clk);
        rc(pcg_pkg::OFS_PWM_ST, 32'h0);
        rc(pcg_pkg::OFS_COUNT, 32'h0);
        irqc(1'b0);
        $display("one shot test done");
        // Auto-reload on channel 2 over divider codes 0 to 4, then a new period
        wr(pcg_pkg::OFS_PRESCALE, 32'h0000_0100);
        for (int i = 0; i < 6; i++) begin
            sel = (i < 5) ? i : 0;
            pv  = (i < 5) ? 3 : 7;
            wr(pcg_pkg::OFS_CLKDIV, 32'(sel) << 8);
            wr(pcg_pkg::OFS_PERIOD + 8'h08, 32'(pv));
            wr(pcg_pkg::OFS_COMPARE + 8'h08, 32'(pv / 2));
            if (i == 0) wr(pcg_pkg::OFS_CTRL, 32'h0000_0404);
            meas(2, h, p);
            meas(2, h, p);
            chk("high time", 32'((pv / 2 + 1) * (2 << sel)), 32'(h));
            chk("period", 32'((pv + 1) * (2 << sel)), 32'(p));
        end
        $display("auto reload test done");
        // Complementary pair 0 with dead time 3
        wr(pcg_pkg::OFS_CTRL, 32'h0);
        wr(pcg_pkg::OFS_PRESCALE, 32'h0000_0003);
        wr(pcg_pkg::OFS_DEADTIME, 32'h0000_0003);
        wr(pcg_pkg::OFS_PERIOD, 32'h3);
        wr(pcg_pkg::OFS_COMPARE, 32'h1);
        wr(pcg_pkg::OFS_CTRL, 32'h0001_0101);
        for (int c = 0; c < 2; c++) begin
            meas(c, h, p);
            meas(c, h, p);
            chk("pair high", 32'h4, 32'(h));
            chk("pair period", 32'h10, 32'(p));
        end
        $display("dead zone test done");
        // Capture on channels 5 and 6 with slow timers set up first
        wr(pcg_pkg::OFS_CTRL, 32'h0);
        wr(pcg_pkg::OFS_PWM_IE, 32'h0);
        wr(pcg_pkg::OFS_PRESCALE, 32'hFFFF_0000);
        wr(pcg_pkg::OFS_CLKDIV, 32'h0440_0000);
        wr(pcg_pkg::OFS_PERIOD + 8'h14, 32'h1234);
        wr(pcg_pkg::OFS_PERIOD + 8'h18, 32'h1234);
        wr(pcg_pkg::OFS_CTRL, 32'h0000_6060);
        wr(pcg_pkg::OFS_CAPCTL + 8'h08, 32'h0007_0000);
        wr(pcg_pkg::OFS_CAPCTL + 8'h0C, 32'h0000_0003);
        @(negedge core_clk);
        chk("pin enables", 32'h9F, 32'(pwm_oe));
        @(posedge core_clk);
        src_lvl <= 8'h60;
        repeat (3) @(posedge core_clk);
        src_lvl <= 8'h00;
        repeat (3) @(posedge core_clk);
        rc(pcg_pkg::OFS_CAP_ST, 32'h0000_1C00);
        rc(pcg_pkg::OFS_CAP_ST, 32'h0);
        rc(pcg_pkg::OFS_RISE + 8'h14, 32'h1234);
        rc(pcg_pkg::OFS_FALL + 8'h14, 32'h1234);
        rc(pcg_pkg::OFS_RISE + 8'h18, 32'h1234);
        irqc(1'b0);
        $display("capture test done");
        give_verdict();
    end
endmodule // testbench
